// >>> design/smi2c_slave.sv
// Purpose: slave end of the two-wire serial memory front end
// Assumes: srst models the power-on reset; straps pulled low outside when floating
// Notes: memory array and address counters live outside, on the user side
`timescale 1ns/1ps
module smi2c_slave #(
  parameter int unsigned POWERUP_CYC = smi2c_pkg::POWERUP_CYC,
  parameter int unsigned WRITE_CYC = smi2c_pkg::WRITE_CYC,
  parameter bit HAS_STRAPS = 1'b1
) (
  input wire logic sys_clk,
  input wire logic srst,
  smi2c_bus_if.slave bus,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect,
  input wire logic [7:0] tx_byte,
  output logic ready_q,
  output logic selected_q,
  output logic read_dir_q,
  output logic [7:0] rx_byte_q,
  output logic rx_valid_q,
  output logic tx_req_q,
  output logic master_ack_q,
  output logic busy_q,
  output logic wp_reject_q
);
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WDATA, ST_RDATA, ST_IGNORE} smi2c_st_e;
  smi2c_st_e st_q;
  logic [1:0] scl_sync_q, sda_sync_q, wp_sync_q;
  logic [2:0] strap_sync1_q, strap_sync2_q;
  logic scl_f_q, sda_f_q, scl_prev_q, sda_prev_q;
  logic [3:0] scl_cnt_q, sda_cnt_q;
  logic [31:0] pu_cnt_q, wr_cnt_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic ack_phase_q, wp_latch_q, wr_pending_q, sda_oe_n_q;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [2:0] sel_bits;

  // two-flop synchronisers for all pin inputs
  always_ff @(posedge sys_clk) begin
    scl_sync_q <= {scl_sync_q[0], bus.scl};
    sda_sync_q <= {sda_sync_q[0], bus.sda};
    wp_sync_q <= {wp_sync_q[0], write_protect};
    strap_sync1_q <= {select_strap_bit2, select_strap_bit1, select_strap_bit0};
    strap_sync2_q <= strap_sync1_q;
  end

  // glitch filters: level must hold GLITCH_CYC + 1 cycles before it is taken
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_cnt_q <= 4'h0;
      sda_cnt_q <= 4'h0;
    end else begin
      if (scl_sync_q[1] == scl_f_q) scl_cnt_q <= 4'h0;
      else if (scl_cnt_q == 4'(smi2c_pkg::GLITCH_CYC)) begin
        scl_f_q <= scl_sync_q[1];
        scl_cnt_q <= 4'h0;
      end else scl_cnt_q <= scl_cnt_q + 4'h1;
      if (sda_sync_q[1] == sda_f_q) sda_cnt_q <= 4'h0;
      else if (sda_cnt_q == 4'(smi2c_pkg::GLITCH_CYC)) begin
        sda_f_q <= sda_sync_q[1];
        sda_cnt_q <= 4'h0;
      end else sda_cnt_q <= sda_cnt_q + 4'h1;
    end
  end

  // edge history of filtered lines
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_f_q;
      sda_prev_q <= sda_f_q;
    end
  end

  assign scl_rise = scl_f_q & ~scl_prev_q;
  assign scl_fall = ~scl_f_q & scl_prev_q;
  assign start_ev = scl_f_q & scl_prev_q & sda_prev_q & ~sda_f_q;
  assign stop_ev = scl_f_q & scl_prev_q & ~sda_prev_q & sda_f_q;
  // strapless variant compares to zero; straps arrive pulled low when floating
  assign sel_bits = HAS_STRAPS ? strap_sync2_q : smi2c_pkg::NO_STRAP_SEL;

  // power-up delay before commands are honoured
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pu_cnt_q <= 32'h0;
      ready_q <= 1'b0;
    end else if (pu_cnt_q >= POWERUP_CYC - 1) ready_q <= 1'b1;
    else pu_cnt_q <= pu_cnt_q + 32'h1;
  end

  // internal write cycle timer, started by stop after accepted write data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_q <= 1'b0;
      wr_cnt_q <= 32'h0;
    end else if (busy_q) begin
      if (wr_cnt_q >= WRITE_CYC - 1) busy_q <= 1'b0;
      else wr_cnt_q <= wr_cnt_q + 32'h1;
    end else if (stop_ev && wr_pending_q) begin
      busy_q <= 1'b1;
      wr_cnt_q <= 32'h0;
    end
  end

  // protocol state, shifting and acknowledge
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h0;
      ack_phase_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
      selected_q <= 1'b0;
      read_dir_q <= 1'b0;
      rx_byte_q <= 8'h0;
      rx_valid_q <= 1'b0;
      tx_req_q <= 1'b0;
      master_ack_q <= 1'b0;
      wp_latch_q <= 1'b0;
      wr_pending_q <= 1'b0;
      wp_reject_q <= 1'b0;
    end else begin
      rx_valid_q <= 1'b0;
      tx_req_q <= 1'b0;
      if (!ready_q) begin
        st_q <= ST_IDLE;
      end else if (start_ev) begin
        st_q <= ST_ADDR;
        bit_q <= 4'h0;
        ack_phase_q <= 1'b0;
        sda_oe_n_q <= 1'b1;
        selected_q <= 1'b0;
        wp_reject_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= ST_IDLE;
        sda_oe_n_q <= 1'b1;
        selected_q <= 1'b0;
        wr_pending_q <= 1'b0;
      end else if (st_q != ST_IDLE && st_q != ST_IGNORE) begin
        if (scl_rise) begin
          if (!ack_phase_q) begin
            sh_q <= {sh_q[6:0], sda_f_q};
            bit_q <= bit_q + 4'h1;
          end else if (st_q == ST_RDATA) begin
            master_ack_q <= ~sda_f_q;
            if (sda_f_q) st_q <= ST_IGNORE;
          end
        end else if (scl_fall) begin
          if (bit_q == 4'(smi2c_pkg::BYTE_BITS) && !ack_phase_q) begin
            ack_phase_q <= 1'b1;
            bit_q <= 4'h0;
            sda_oe_n_q <= 1'b1;
            if (st_q == ST_ADDR) begin
              if (sh_q[7:4] == smi2c_pkg::DEV_PREFIX && sh_q[3:1] == sel_bits
                  && !busy_q) begin
                sda_oe_n_q <= 1'b0;
                selected_q <= 1'b1;
                read_dir_q <= sh_q[0];
              end else st_q <= ST_IGNORE;
            end else if (st_q == ST_WDATA) begin
              rx_byte_q <= sh_q;
              if (wp_latch_q) begin
                wp_reject_q <= 1'b1;
                st_q <= ST_IGNORE;
              end else begin
                rx_valid_q <= 1'b1;
                wr_pending_q <= 1'b1;
                sda_oe_n_q <= 1'b0;
              end
            end
          end else if (ack_phase_q) begin
            ack_phase_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
            if (st_q == ST_ADDR) begin
              st_q <= read_dir_q ? ST_RDATA : ST_WDATA;
              // last fall before the first data byte; strapless variant has no protect pin
              wp_latch_q <= HAS_STRAPS ? wp_sync_q[1] : 1'b0;
              if (read_dir_q) begin
                sh_q <= tx_byte;
                tx_req_q <= 1'b1;
                sda_oe_n_q <= tx_byte[7];
              end
            end else if (st_q == ST_RDATA) begin
              sh_q <= tx_byte;
              tx_req_q <= 1'b1;
              sda_oe_n_q <= tx_byte[7];
            end
          end else if (st_q == ST_RDATA) begin
            sda_oe_n_q <= sh_q[7];
          end
        end
      end
    end
  end

  // open drain: pull low only, otherwise release
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe_n = sda_oe_n_q;
endmodule

// >>> design/smi2c_pkg.sv
// Purpose: shared constants for the two-wire serial memory slave front end
// Assumes: sys_clk at 40 MHz
// Notes: times in ns or us, counts derived from the clock period
package smi2c_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // glitch filter width and derived cycle count (least time, rounded up)
  localparam int unsigned GLITCH_NS = 100;
  localparam int unsigned GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // powerup_ready_delay in us, longest time, rounded down
  localparam int unsigned POWERUP_READY_DELAY_US = 1000;
  localparam int unsigned POWERUP_CYC = POWERUP_READY_DELAY_US * 1000 / CLK_PERIOD_NS;
  // internal_write_cycle_time in us
  localparam int unsigned INTERNAL_WRITE_CYCLE_TIME_US = 5000;
  localparam int unsigned WRITE_CYC = INTERNAL_WRITE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
  // address byte layout
  localparam logic [3:0] DEV_PREFIX = 4'ha;
  localparam logic [2:0] NO_STRAP_SEL = 3'h0;
  // master clock divider: quarter period of the serial clock is SCL_HALF_CYC / 2 + 1 sys_clk cycles
  localparam int unsigned SCL_HALF_CYC = 63;
  localparam int unsigned BYTE_BITS = 8;
endpackage

// >>> design/smi2c_bus_if.sv
// Purpose: two-wire bus between master and memory slave
// Assumes: open-drain lines with pull-ups resolved here
// Notes: output enable low means the line is pulled low
`timescale 1ns/1ps
interface smi2c_bus_if;
  logic scl_m_o;
  logic scl_m_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  logic scl;
  logic sda;
  // wired-and with pull-up
  assign scl = scl_m_oe_n ? 1'b1 : scl_m_o;
  assign sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
  modport master (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n,
    input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe_n, input scl, input sda);
endinterface

// >>> design/smi2c_master.sv
// Purpose: master end driving the serial clock and issuing transfers
// Assumes: one byte per request, user sequences start, bytes and stop
// Notes: clock derived from sys_clk by a divider
`timescale 1ns/1ps
module smi2c_master (
  input wire logic sys_clk,
  input wire logic srst,
  smi2c_bus_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_ack,
  input wire logic [7:0] cmd_byte,
  output logic cmd_ready_q,
  output logic done_q,
  output logic [7:0] rd_byte_q,
  output logic ack_seen_q
);
  typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BITS, MS_STOP} smi2c_ms_e;
  smi2c_ms_e st_q;
  logic [6:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [1:0] sda_sync_q;
  logic scl_q, sda_q, rd_q, stop_q, bus_held_q;
  logic tick;

  always_ff @(posedge sys_clk) sda_sync_q <= {sda_sync_q[0], bus.sda};

  assign tick = (div_q == 7'(smi2c_pkg::SCL_HALF_CYC / 2));

  // quarter-period divider
  always_ff @(posedge sys_clk) begin
    if (srst || st_q == MS_IDLE) div_q <= 7'h0;
    else if (tick) div_q <= 7'h0;
    else div_q <= div_q + 7'h1;
  end

  // sequencer: each bit is four quarter phases; bits move sda only while scl low, start and stop move it with scl high
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= MS_IDLE;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h1ff;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rd_q <= 1'b0;
      stop_q <= 1'b0;
      bus_held_q <= 1'b0;
      cmd_ready_q <= 1'b0;
      done_q <= 1'b0;
      rd_byte_q <= 8'h0;
      ack_seen_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        MS_IDLE: begin
          cmd_ready_q <= 1'b1;
          if (cmd_valid && cmd_ready_q) begin
            cmd_ready_q <= 1'b0;
            rd_q <= cmd_read;
            stop_q <= cmd_stop;
            sh_q <= cmd_read ? {8'hff, ~cmd_ack} : {cmd_byte, 1'b1};
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            // a start when requested or when the bus is idle, otherwise straight into the bits
            st_q <= (cmd_start || !bus_held_q) ? MS_START : MS_BITS;
          end
        end
        MS_START: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b0;
            default: begin
              scl_q <= 1'b0;
              bus_held_q <= 1'b1;
              st_q <= MS_BITS;
            end
          endcase
        end
        MS_BITS: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= sh_q[8];
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (bit_q < 4'h8) rd_byte_q <= {rd_byte_q[6:0], sda_sync_q[1]};
              else ack_seen_q <= ~sda_sync_q[1];
            end
            default: begin
              scl_q <= 1'b0;
              sh_q <= {sh_q[7:0], 1'b1};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                st_q <= stop_q ? MS_STOP : MS_IDLE;
                if (!stop_q) done_q <= 1'b1;
              end
            end
          endcase
        end
        MS_STOP: if (tick) begin
          ph_q <= ph_q + 2'h1;
          case (ph_q)
            2'h0: sda_q <= 1'b0;
            2'h1: scl_q <= 1'b1;
            2'h2: sda_q <= 1'b1;
            default: begin
              bus_held_q <= 1'b0;
              done_q <= 1'b1;
              st_q <= MS_IDLE;
            end
          endcase
        end
        default: st_q <= MS_IDLE;
      endcase
    end
  end

  // open-drain drivers
  assign bus.scl_m_o = 1'b0;
  assign bus.scl_m_oe_n = scl_q;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe_n = sda_q;
endmodule

// >>> sim/smi2c_sva.sv
// Purpose: bus checker for the two-wire memory front end
// Assumes: plain inputs taken from the bus interface
// Notes: slave timing judged against the master serial clock
`timescale 1ns/1ps
module smi2c_sva (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_m_o,
  input wire logic scl_m_oe_n,
  input wire logic sda_s_o,
  input wire logic sda_s_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic scl_q;
  logic sda_q;
  logic [3:0] rise_q;
  logic [10:0] low_q;
  // previous line levels
  always_ff @(posedge sys_clk) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // clock rises since the last start
  always_ff @(posedge sys_clk) begin
    if (srst || (scl && scl_q && sda_q && !sda)) begin
      rise_q <= 4'h0;
    end else if (scl && !scl_q && rise_q != 4'hf) begin
      rise_q <= rise_q + 4'h1;
    end
  end
  // cycles the slave has held the data line low
  always_ff @(posedge sys_clk) begin
    if (srst || sda_s_oe_n) begin
      low_q <= 11'h0;
    end else begin
      low_q <= low_q + 11'h1;
    end
  end
  a_slave_pulls_only: assert property (!sda_s_oe_n |-> !sda_s_o)
    else $error("slave drove data line high");
  a_master_clk_only: assert property (!scl_m_oe_n |-> !scl_m_o)
    else $error("master drove clock line high");
  a_pull_after_fall: assert property ($fell(sda_s_oe_n) |-> !scl && !$past(scl, 2))
    else $error("slave pulled data not after clock fall");
  a_release_scl_low: assert property ($rose(sda_s_oe_n) |-> !scl)
    else $error("slave released data while clock high");
  a_stable_scl_high: assert property (scl && scl_q |-> $stable(sda_s_oe_n))
    else $error("slave data changed while clock high");
  a_stop_quiet: assert property (scl && scl_q && $rose(sda) |=> sda_s_oe_n [*8])
    else $error("slave drove data after stop");
  a_start_quiet: assert property (scl && scl_q && $fell(sda) |-> sda_s_oe_n [*8])
    else $error("slave drove data after start");
  a_ack_after_byte: assert property ($fell(sda_s_oe_n) |-> rise_q >= 4'h8)
    else $error("slave answered before eight address bits");
  a_drive_bounded: assert property (low_q < 11'd1200)
    else $error("slave held data low too long");
  c_slave_ack: cover property ($fell(sda_s_oe_n));
  c_stop_seen: cover property (scl && scl_q && $rose(sda));
  c_start_seen: cover property (scl && scl_q && $fell(sda));
endmodule

// >>> sim/smi2c_tb_top.sv
// Purpose: self-checking bench joining master and slave ends
// Assumes: scaled power-up and write-cycle counts
// Notes: random addresses from a fixed seed with corner cases
`timescale 1ns/1ps
module smi2c_tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic select_strap_bit0 = 1'b0, select_strap_bit1 = 1'b0, select_strap_bit2 = 1'b0;
  logic write_protect = 1'b0;
  logic [7:0] tx_byte = 8'h00, cmd_byte = 8'h00, rx_byte_q, rd_byte_q;
  logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0, cmd_ack = 1'b0;
  logic ready_q, selected_q, read_dir_q, rx_valid_q, tx_req_q, master_ack_q, busy_q;
  logic wp_reject_q, cmd_ready_q, done_q, ack_seen_q;
  int seed = 47475;
  int error_cnt = 0;
  int compares = 0;
  int rx_cnt = 0;
  int tx_cnt = 0;
  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;
  // count one-cycle strobes from the slave
  always @(posedge sys_clk) begin
    if (rx_valid_q === 1'b1) rx_cnt <= rx_cnt + 1;
    if (tx_req_q === 1'b1) tx_cnt <= tx_cnt + 1;
  end
  smi2c_bus_if bus ();
  smi2c_master smi2c_master_inst (.sys_clk(sys_clk), .srst(srst), .bus(bus.master),
    .cmd_valid(cmd_valid), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_ack(cmd_ack), .cmd_byte(cmd_byte), .cmd_ready_q(cmd_ready_q), .done_q(done_q),
    .rd_byte_q(rd_byte_q), .ack_seen_q(ack_seen_q));
  smi2c_slave #(.POWERUP_CYC(50), .WRITE_CYC(3000), .HAS_STRAPS(1'b1)) smi2c_slave_inst (
    .sys_clk(sys_clk), .srst(srst), .bus(bus.slave), .select_strap_bit0(select_strap_bit0),
    .select_strap_bit1(select_strap_bit1), .select_strap_bit2(select_strap_bit2),
    .write_protect(write_protect), .tx_byte(tx_byte), .ready_q(ready_q),
    .selected_q(selected_q), .read_dir_q(read_dir_q), .rx_byte_q(rx_byte_q),
    .rx_valid_q(rx_valid_q), .tx_req_q(tx_req_q), .master_ack_q(master_ack_q),
    .busy_q(busy_q), .wp_reject_q(wp_reject_q));
  smi2c_sva smi2c_sva_inst (.sys_clk(sys_clk), .srst(srst), .scl(bus.scl), .sda(bus.sda),
    .scl_m_o(bus.scl_m_o), .scl_m_oe_n(bus.scl_m_oe_n), .sda_s_o(bus.sda_s_o),
    .sda_s_oe_n(bus.sda_s_oe_n));
  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // expected acknowledge of an address byte
  function automatic logic exp_ack(input logic [7:0] a, input logic [2:0] s);
    return a[7:4] == smi2c_pkg::DEV_PREFIX && a[3:1] == s;
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: pick = ready_q;
      1: pick = cmd_ready_q;
      2: pick = done_q;
      default: pick = ~busy_q;
    endcase
  endfunction
  // bounded wait on a status flag
  task automatic wait_on(input int w, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n > lim) begin
        chk(8'h00, 8'h01);
        finish_test();
      end
    end while (pick(w) !== 1'b1);
  endtask
  // one byte command: flags are start, stop, read, ack
  task automatic xfer(input logic [3:0] f, input logic [7:0] b);
    {cmd_start, cmd_stop, cmd_read, cmd_ack} <= f;
    cmd_byte <= b;
    cmd_valid <= 1'b1;
    wait_on(1, 3000);
    cmd_valid <= 1'b0;
    wait_on(2, 3000);
  endtask
  initial begin
    logic [7:0] a;
    logic [2:0] st;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk(ready_q, 1'b0);
    wait_on(0, 55);
    // address probes, floating straps first
    for (int i = 0; i < 12; i++) begin
      st = (i == 0) ? 3'h0 : 3'($random(seed));
      a = 8'($random(seed));
      if (i < 8) a = {4'ha, (i[0] ? a[3:1] : st), 1'b0};
      a[0] = 1'b0;
      {select_strap_bit2, select_strap_bit1, select_strap_bit0} <= st;
      repeat (4) @(posedge sys_clk);
      xfer(4'hc, a);
      chk(ack_seen_q, exp_ack(a, st));
    end
    // read two bytes, master acks the first and declines the second
    tx_byte <= 8'($random(seed));
    xfer(4'h8, {4'ha, st, 1'b1});
    chk(ack_seen_q, 1'b1);
    chk(read_dir_q, 1'b1);
    chk(selected_q, 1'b1);
    xfer(4'h3, 8'h00);
    chk(rd_byte_q, tx_byte);
    chk(master_ack_q, 1'b1);
    xfer(4'h6, 8'h00);
    chk(rd_byte_q, tx_byte);
    chk(master_ack_q, 1'b0);
    chk(8'(tx_cnt), 8'h02);
    // protected write is refused at the data byte
    write_protect <= 1'b1;
    xfer(4'h8, {4'ha, st, 1'b0});
    xfer(4'h4, 8'h5a);
    chk(ack_seen_q, 1'b0);
    chk(wp_reject_q, 1'b1);
    chk(busy_q, 1'b0);
    chk(8'(rx_cnt), 8'h00);
    write_protect <= 1'b0;
    // mismatch, stray byte, then repeated start into a write
    xfer(4'h8, {4'h5, st, 1'b0});
    chk(ack_seen_q, 1'b0);
    chk(selected_q, 1'b0);
    xfer(4'h0, 8'h00);
    chk(ack_seen_q, 1'b0);
    xfer(4'h8, {4'ha, st, 1'b0});
    chk(ack_seen_q, 1'b1);
    a = 8'($random(seed));
    xfer(4'h4, a);
    chk(ack_seen_q, 1'b1);
    chk(rx_byte_q, a);
    chk(8'(rx_cnt), 8'h01);
    repeat (4) @(posedge sys_clk);
    chk(busy_q, 1'b1);
    xfer(4'hc, {4'ha, st, 1'b0});
    chk(ack_seen_q, 1'b0);
    wait_on(3, 3000);
    xfer(4'hc, {4'ha, st, 1'b0});
    chk(ack_seen_q, 1'b1);
    // second reset in mid-run
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk(ready_q, 1'b0);
    wait_on(0, 55);
    xfer(4'hc, {4'ha, st, 1'b0});
    chk(ack_seen_q, 1'b1);
    finish_test();
  end
endmodule
